// ---- src/ivm_regs.vh ----
// Constants of the interrupt vector and mask unit: offsets, fields, slots and priorities.
`ifndef IVM_REGS_VH
`define IVM_REGS_VH

// ****************************************************************
// Register word offsets on the Avalon-MM port (byte offset / 4)
// ****************************************************************
`define IVM_A_PEND_LO 4'h0
`define IVM_A_PEND_HI 4'h1
`define IVM_A_EN_LO 4'h2
`define IVM_A_EN_HI 4'h3
`define IVM_A_HEN_LO 4'h4
`define IVM_A_HEN_HI 4'h5
`define IVM_A_CTRL 4'h6
`define IVM_A_IRQ_STAT 4'h7
`define IVM_A_IRQ_MASK 4'h8
`define IVM_A_STATE 4'h9

// ****************************************************************
// Field layouts and reset values
// ****************************************************************
`define IVM_ZERO32 32'h00000000
`define IVM_ZERO16 16'h0000
`define IVM_MASKABLE 32'hFFFFFFFC
`define IVM_MASKABLE_LO 16'hFFFC
`define IVM_FLAGGED 32'hFFFFFFFE
`define IVM_CTRL_ROUTE 0
`define IVM_EV_PEND 0
`define IVM_EV_ACK 1
`define IVM_EV_W 2
`define IVM_EV_ZERO 2'b00
`define IVM_VEC_SHIFT 3'h3

// ****************************************************************
// Vector slots of hardware sources
// ****************************************************************
`define IVM_S_RESET 5'd0
`define IVM_S_NMI 1
`define IVM_S_EXT0 2
`define IVM_S_EXT2 3
`define IVM_S_TIM0 4
`define IVM_S_SRX0 5
`define IVM_S_SRX1 6
`define IVM_S_STX1 7
`define IVM_S_PLL 8
`define IVM_S_DMA1 9
`define IVM_S_HOST 10
`define IVM_S_EXT3 11
`define IVM_S_DMA4 14
`define IVM_S_DMA5 15
`define IVM_S_EXT1 16
`define IVM_S_STX0 17
`define IVM_S_DMA0 18
`define IVM_S_DMA2 20
`define IVM_S_DMA3 21
`define IVM_S_TIM1 22
`define IVM_S_I2C 23
`define IVM_S_BUS_ERROR_REQUEST 24
`define IVM_S_DATA_LOG_REQUEST 25
`define IVM_S_OSDBG 26

// Slot holding each priority level, level 0 in the low five bits.
`define IVM_PRIO_ORDER {5'd31, 5'd30, 5'd29, 5'd28, 5'd27, 5'd26, 5'd25, 5'd23, \
  5'd22, 5'd15, 5'd14, 5'd21, 5'd20, 5'd13, 5'd12, 5'd19, 5'd11, 5'd10, 5'd9, \
  5'd18, 5'd8, 5'd7, 5'd6, 5'd17, 5'd5, 5'd4, 5'd3, 5'd16, 5'd2, 5'd24, 5'd1, 5'd0}

// Pin detector history: one high sample then three lows.
`define IVM_PIN_HIT 4'b1000
`define IVM_PIN_IDLE 4'hF

`endif

// ---- src/ivm_pin_detect.v ----
// Synchroniser and falling-request detector for one active-low interrupt pin.
`timescale 1ns/10ps
`include "ivm_regs.vh"

module ivm_pin_detect (
  input wire clk,
  input wire rst_n,
  input wire pin_n,
  output reg hit
);

  reg sync1;
  reg sync2;
  reg [3:0] hist;

  // ****************************************************************
  // Two-stage synchroniser and pattern check
  // ****************************************************************

  // RULE_15: synchronise then match 1-0-0-0.
  // Only the second stage feeds the history, so a metastable first stage never
  // reaches the matcher. A low shorter than three clocks is never reported.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      hist <= `IVM_PIN_IDLE;
      hit <= 1'b0;
    end else begin
      sync1 <= pin_n;
      sync2 <= sync1;
      hist <= {hist[2:0], sync2};
      hit <= ({hist[2:0], sync2} == `IVM_PIN_HIT);
    end
  end

endmodule

// ---- src/ivm_top.v ----
// Interrupt vector, priority and mask unit with an Avalon-MM register port.
`timescale 1ns/10ps
`include "ivm_regs.vh"

// How it works
// RULE_01: Thirty-two slots; vector location equals slot number times eight bytes.
// RULE_02: Fixed priority per slot; lower number wins; reset 0, nonmaskable 1, bus error 2.
// RULE_03: Slot 11 takes external line 3, or the watchdog when routing selects it.
// RULE_04: DMA completions land on slots 18, 9, 20, 21, 14 and 15.
// RULE_05: Slot 25 data log, 26 OS debug; 12, 13, 19, 27-31 trap only.
// RULE_06: Normal enable words mask or pass each maskable request in running mode.
// RULE_07: Pending flag words hold one bit per request not yet serviced.
// RULE_08: Halted enable words apply only while the CPU is halted in emulation.
// RULE_09: Halted CPU services a request only if both enable words allow it.
// RULE_10: Software loads the halted enable words before entering halted emulation.
// RULE_11: Hardware reset zeroes pending, normal enable and halted enable words.
// RULE_12: Software reset zeroes pending words and keeps both enable word pairs.
// RULE_13: Software writes zero into the reserved must-be-zero enable bit.
// RULE_14: Reset slot serves both resets; nonmaskable slot cannot be masked.
// RULE_15: External pins pass two flops and need high then three lows.
// RULE_16: Vector fetch pulses acknowledge low one clock and clears that flag.
// RULE_17: Among eligible pending requests the lowest priority number is presented.
// RULE_18: Requests set flags regardless of enables; flags hold until taken or cleared.
module ivm_top (
  input wire SYS_CLK,
  input wire RESETN,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  input wire NMI_N,
  input wire [3:0] EXT_REQ_N,
  input wire WATCHDOG_REQUEST,
  input wire [1:0] TIMER_REQ,
  input wire [1:0] SERIAL_RX_REQ,
  input wire [1:0] SERIAL_TX_REQ,
  input wire PLL_LOCK_REQUEST,
  input wire [5:0] DMA_DONE_REQ,
  input wire HOST_REQUEST,
  input wire I2C_REQ,
  input wire BUS_ERROR_REQUEST,
  input wire DATA_LOG_REQUEST,
  input wire OS_DEBUG_REQUEST,
  input wire CPU_HALTED,
  input wire CPU_SOFT_RESET,
  input wire CPU_VECTOR_FETCH,
  output reg INT_REQ,
  output reg [4:0] INT_SLOT,
  output reg [7:0] INT_VECTOR,
  output reg VECTOR_FETCH_ACK_N,
  output reg IRQ
);

  // ****************************************************************
  // Reset release and state
  // ****************************************************************

  reg rst_meta;
  reg rst_n;
  reg [31:0] pend;
  reg [31:0] en;
  reg [31:0] hen;
  reg reset_pend;
  reg route_wdt;
  reg [1:0] ev_stat;
  reg [1:0] ev_mask;
  reg [31:0] raw;
  reg [31:0] elig;
  reg [31:0] next_pend;
  reg [31:0] rd_mux;
  reg found;
  reg [4:0] win_slot;
  reg [1:0] next_ev;
  wire [4:0] ext_hit;
  wire [159:0] prio_order;
  wire [31:0] elig_by_prio;
  wire bus_req;
  wire wr_now;
  wire take;
  wire [31:0] clr_mask;
  wire [31:0] ack_mask;
  integer i;

  // The reset is asserted at once but released only after two clean edges.
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************************************
  // External pins and request mapping
  // ****************************************************************

  // RULE_15: one detector per pin.
  // Entry 4 is the nonmaskable pin, entries 0 to 3 the external request lines.
  wire [4:0] pins_n;
  assign pins_n = {NMI_N, EXT_REQ_N};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : pin_gen
      ivm_pin_detect u_pin (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .pin_n(pins_n[g]),
        .hit(ext_hit[g])
      );
    end
  endgenerate

  // Internal sources are on this clock already, so they are read directly.
  // Slots 12, 13, 19 and 27 to 31 stay zero: they exist for software traps only.
  always @* begin
    raw = `IVM_ZERO32;
    raw[`IVM_S_NMI] = ext_hit[4];
    raw[`IVM_S_EXT0] = ext_hit[0];
    raw[`IVM_S_EXT1] = ext_hit[1];
    raw[`IVM_S_EXT2] = ext_hit[2];
    // RULE_03: watchdog routing mux.
    raw[`IVM_S_EXT3] = route_wdt ? WATCHDOG_REQUEST : ext_hit[3];
    raw[`IVM_S_TIM0] = TIMER_REQ[0];
    raw[`IVM_S_TIM1] = TIMER_REQ[1];
    raw[`IVM_S_SRX0] = SERIAL_RX_REQ[0];
    raw[`IVM_S_SRX1] = SERIAL_RX_REQ[1];
    raw[`IVM_S_STX0] = SERIAL_TX_REQ[0];
    raw[`IVM_S_STX1] = SERIAL_TX_REQ[1];
    raw[`IVM_S_PLL] = PLL_LOCK_REQUEST;
    // RULE_04: DMA channel slots.
    raw[`IVM_S_DMA0] = DMA_DONE_REQ[0];
    raw[`IVM_S_DMA1] = DMA_DONE_REQ[1];
    raw[`IVM_S_DMA2] = DMA_DONE_REQ[2];
    raw[`IVM_S_DMA3] = DMA_DONE_REQ[3];
    raw[`IVM_S_DMA4] = DMA_DONE_REQ[4];
    raw[`IVM_S_DMA5] = DMA_DONE_REQ[5];
    raw[`IVM_S_HOST] = HOST_REQUEST;
    raw[`IVM_S_I2C] = I2C_REQ;
    raw[`IVM_S_BUS_ERROR_REQUEST] = BUS_ERROR_REQUEST;
    // RULE_05: data log and debug slots.
    raw[`IVM_S_DATA_LOG_REQUEST] = DATA_LOG_REQUEST;
    raw[`IVM_S_OSDBG] = OS_DEBUG_REQUEST;
  end

  // ****************************************************************
  // Eligibility and priority
  // ****************************************************************

  // RULE_06: normal enables gate maskable requests.
  // RULE_08: halted enables count only while halted.
  // RULE_09: halted service needs both enables.
  // RULE_14: reset and nonmaskable slots bypass enables.
  always @* begin
    elig = pend & en & (CPU_HALTED ? hen : ~`IVM_ZERO32) & `IVM_MASKABLE;
    elig[`IVM_S_NMI] = pend[`IVM_S_NMI];
    elig[`IVM_S_RESET] = reset_pend;
  end

  // RULE_02: reorder eligibility by priority.
  assign prio_order = `IVM_PRIO_ORDER;
  generate
    for (g = 0; g < 32; g = g + 1) begin : prio_gen
      assign elig_by_prio[g] = elig[prio_order[g*5 +: 5]];
    end
  endgenerate

  // RULE_17: lowest priority number wins.
  // Scanning downward lets the last hit, the lowest level, stand.
  always @* begin
    found = 1'b0;
    win_slot = `IVM_S_RESET;
    for (i = 31; i >= 0; i = i - 1) begin
      if (elig_by_prio[i]) begin
        found = 1'b1;
        win_slot = prio_order[i*5 +: 5];
      end
    end
  end

  // RULE_16: acknowledge only a presented slot that is still eligible.
  // An enable cleared after presentation withdraws the request, so no ack.
  assign take = CPU_VECTOR_FETCH && INT_REQ && elig[INT_SLOT];
  assign ack_mask = take ? (`IVM_ZERO32 | (32'h1 << INT_SLOT)) : `IVM_ZERO32;

  // ****************************************************************
  // Avalon-MM slave handshake
  // ****************************************************************

  // One wait cycle per access: the edge that drops waitrequest also loads
  // read data, and the following edge completes the transfer.
  assign bus_req = AVS_READ || AVS_WRITE;
  assign wr_now = AVS_WRITE && !AVS_WAITREQUEST;
  assign clr_mask = (wr_now && AVS_ADDRESS == `IVM_A_PEND_LO) ?
                    {`IVM_ZERO16, AVS_WRITEDATA[15:0]} :
                    (wr_now && AVS_ADDRESS == `IVM_A_PEND_HI) ?
                    {AVS_WRITEDATA[15:0], `IVM_ZERO16} : `IVM_ZERO32;

  // Unmapped offsets read as zero and ignore writes.
  always @* begin
    case (AVS_ADDRESS)
      `IVM_A_PEND_LO: rd_mux = {`IVM_ZERO16, pend[15:0]};
      `IVM_A_PEND_HI: rd_mux = {`IVM_ZERO16, pend[31:16]};
      `IVM_A_EN_LO: rd_mux = {`IVM_ZERO16, en[15:0]};
      `IVM_A_EN_HI: rd_mux = {`IVM_ZERO16, en[31:16]};
      `IVM_A_HEN_LO: rd_mux = {`IVM_ZERO16, hen[15:0]};
      `IVM_A_HEN_HI: rd_mux = {`IVM_ZERO16, hen[31:16]};
      `IVM_A_CTRL: rd_mux = {31'h0, route_wdt};
      `IVM_A_IRQ_STAT: rd_mux = {30'h0, ev_stat};
      `IVM_A_IRQ_MASK: rd_mux = {30'h0, ev_mask};
      `IVM_A_STATE: rd_mux = {16'h0, CPU_HALTED, reset_pend, INT_VECTOR, INT_SLOT, INT_REQ};
      default: rd_mux = `IVM_ZERO32;
    endcase
  end

  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= `IVM_ZERO32;
    end else begin
      AVS_WAITREQUEST <= !(bus_req && AVS_WAITREQUEST);
      if (AVS_READ && AVS_WAITREQUEST) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // Pending flags
  // ****************************************************************

  // RULE_18: flags set whatever the enables.
  // RULE_07: flags hold until taken or cleared.
  // A new request in the cycle of a clear or an acknowledge wins over both.
  always @* begin
    next_pend = pend & ~clr_mask & ~ack_mask;
    // RULE_12: software reset clears flags.
    if (CPU_SOFT_RESET) begin
      next_pend = `IVM_ZERO32;
    end
    next_pend = (next_pend | raw) & `IVM_FLAGGED;
  end

  // RULE_11: hardware reset zeroes all words.
  // The reset slot is raised by reset itself, so it sits outside the flag words.
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pend <= `IVM_ZERO32;
      en <= `IVM_ZERO32;
      hen <= `IVM_ZERO32;
      route_wdt <= 1'b0;
      reset_pend <= 1'b1;
    end else begin
      pend <= next_pend;
      // RULE_14: software reset raises reset slot.
      if (CPU_SOFT_RESET) begin
        reset_pend <= 1'b1;
      end else if (take && INT_SLOT == `IVM_S_RESET) begin
        reset_pend <= 1'b0;
      end
      // RULE_13: reserved enable bits never stored.
      if (wr_now && AVS_ADDRESS == `IVM_A_EN_LO) begin
        en[15:0] <= AVS_WRITEDATA[15:0] & `IVM_MASKABLE_LO;
      end
      if (wr_now && AVS_ADDRESS == `IVM_A_EN_HI) begin
        en[31:16] <= AVS_WRITEDATA[15:0];
      end
      // RULE_10: halted enables loaded by software.
      if (wr_now && AVS_ADDRESS == `IVM_A_HEN_LO) begin
        hen[15:0] <= AVS_WRITEDATA[15:0] & `IVM_MASKABLE_LO;
      end
      if (wr_now && AVS_ADDRESS == `IVM_A_HEN_HI) begin
        hen[31:16] <= AVS_WRITEDATA[15:0];
      end
      if (wr_now && AVS_ADDRESS == `IVM_A_CTRL) begin
        route_wdt <= AVS_WRITEDATA[`IVM_CTRL_ROUTE];
      end
    end
  end

  // ****************************************************************
  // CPU-facing outputs
  // ****************************************************************

  // RULE_01: vector location is slot times eight.
  // RULE_16: acknowledge low for one clock.
  // The slot just taken is not re-presented in the same edge since take holds INT_REQ low
  // while its flag clears; presentation follows the flags one clock later.
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      INT_REQ <= 1'b0;
      INT_SLOT <= `IVM_S_RESET;
      INT_VECTOR <= 8'h00;
      VECTOR_FETCH_ACK_N <= 1'b1;
    end else begin
      VECTOR_FETCH_ACK_N <= !take;
      INT_REQ <= found && !take;
      INT_SLOT <= win_slot;
      INT_VECTOR <= {3'b000, win_slot} << `IVM_VEC_SHIFT;
    end
  end

  // ****************************************************************
  // Summary interrupt line
  // ****************************************************************

  // Events: a new request flagged, and a vector acknowledged; set wins over W1C.
  always @* begin
    next_ev = ev_stat;
    if (wr_now && AVS_ADDRESS == `IVM_A_IRQ_STAT) begin
      next_ev = ev_stat & ~AVS_WRITEDATA[1:0];
    end
    next_ev[`IVM_EV_PEND] = next_ev[`IVM_EV_PEND] | (|raw);
    next_ev[`IVM_EV_ACK] = next_ev[`IVM_EV_ACK] | take;
  end

  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ev_stat <= `IVM_EV_ZERO;
      ev_mask <= `IVM_EV_ZERO;
      IRQ <= 1'b0;
    end else begin
      ev_stat <= next_ev;
      if (wr_now && AVS_ADDRESS == `IVM_A_IRQ_MASK) begin
        ev_mask <= AVS_WRITEDATA[1:0];
      end
      IRQ <= |(next_ev & ev_mask);
    end
  end

endmodule

// ---- tb/ivm_cpu_model.sv ----
// Behavioural CPU that fetches the interrupt vector the unit presents.
`timescale 1ns/10ps
// ****
// CPU fetch model
// ****
module ivm_cpu_model (
  input wire clk,
  input wire int_req,
  input wire go,
  input wire [3:0] lag,
  output reg fetch = 1'b0
);
  reg [3:0] cnt = 4'h0;

  // fetch presented vector
  // A slow CPU waits lag cycles; it never fetches on two edges in a row.
  always @(posedge clk) begin
    fetch <= 1'b0;
    if (!go || !int_req || fetch) begin
      cnt <= 4'h0;
    end else if (cnt >= lag) begin
      fetch <= 1'b1;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ---- tb/ivm_checker.sv ----
// Concurrent checks on the ports of the interrupt vector and mask unit.
`timescale 1ns/10ps
// ****
// Port checker
// ****
module ivm_checker (
  input wire SYS_CLK,
  input wire RESETN,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire AVS_WAITREQUEST,
  input wire NMI_N,
  input wire CPU_SOFT_RESET,
  input wire CPU_VECTOR_FETCH,
  input wire INT_REQ,
  input wire [4:0] INT_SLOT,
  input wire [7:0] INT_VECTOR,
  input wire VECTOR_FETCH_ACK_N
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  // A pin seen high, then low on three samples.
  sequence s_pin_low;
    $fell(NMI_N) ##1 !NMI_N [*2];
  endsequence
  sequence s_reset_shown;
    INT_REQ && INT_SLOT == 5'h0;
  endsequence

  a_vector_slot: assert property (INT_VECTOR == {INT_SLOT, 3'b000})
    else $error("vector is not slot times eight");
  a_ack_pulse: assert property ($fell(VECTOR_FETCH_ACK_N) |=> VECTOR_FETCH_ACK_N)
    else $error("acknowledge longer than one clock");
  a_ack_cause: assert property ($fell(VECTOR_FETCH_ACK_N) |->
    $past(CPU_VECTOR_FETCH) && $past(INT_REQ))
    else $error("acknowledge without a fetch of a presented slot");
  a_req_gap: assert property (!VECTOR_FETCH_ACK_N |-> !INT_REQ)
    else $error("request shown during acknowledge");
  a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST)
    else $error("register access not answered after one wait");
  a_bus_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_soft_slot: assert property (CPU_SOFT_RESET |-> ##[1:3] s_reset_shown)
    else $error("software reset did not present slot zero");
  a_hw_slot: assert property ($rose(RESETN) |-> ##[1:4] s_reset_shown)
    else $error("hardware reset did not present slot zero");
  a_pin_nmi: assert property (s_pin_low |-> ##[2:8] (INT_REQ && INT_SLOT <= 5'h1))
    else $error("low pin of three clocks not detected");
endmodule

bind ivm_top ivm_checker u_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .NMI_N(NMI_N),
  .CPU_SOFT_RESET(CPU_SOFT_RESET), .CPU_VECTOR_FETCH(CPU_VECTOR_FETCH),
  .INT_REQ(INT_REQ), .INT_SLOT(INT_SLOT), .INT_VECTOR(INT_VECTOR),
  .VECTOR_FETCH_ACK_N(VECTOR_FETCH_ACK_N));

// ---- tb/ivm_top_tb.sv ----
// Self-checking bench for the interrupt vector and mask unit.
`timescale 1ns/10ps
`include "ivm_regs.vh"
// ****
// Bench top
// ****
module ivm_top_tb;
  reg clk = 0, rst_n = 0, rd = 0, wr = 0, halted = 0, sreset = 0, go = 0;
  reg [3:0] adr = 0, lag = 0;
  reg [31:0] wd = 0, q;
  reg [18:0] src = 0;
  reg [4:0] pn = 5'h1F;
  wire [31:0] rdata;
  wire wait_r, fetch, int_req, ack_n, irq;
  wire [4:0] slot;
  wire [7:0] vec;
  int fail_count = 0, n_checks = 0;

  // Source bits: timers, serial, PLL, six DMA, host, I2C, bus error, log, OS, watchdog.
  ivm_top dut (.SYS_CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
    .NMI_N(pn[4]), .EXT_REQ_N(pn[3:0]), .WATCHDOG_REQUEST(src[18]),
    .TIMER_REQ(src[1:0]), .SERIAL_RX_REQ(src[3:2]), .SERIAL_TX_REQ(src[5:4]),
    .PLL_LOCK_REQUEST(src[6]), .DMA_DONE_REQ(src[12:7]), .HOST_REQUEST(src[13]),
    .I2C_REQ(src[14]), .BUS_ERROR_REQUEST(src[15]), .DATA_LOG_REQUEST(src[16]),
    .OS_DEBUG_REQUEST(src[17]), .CPU_HALTED(halted), .CPU_SOFT_RESET(sreset),
    .CPU_VECTOR_FETCH(fetch), .INT_REQ(int_req), .INT_SLOT(slot), .INT_VECTOR(vec),
    .VECTOR_FETCH_ACK_N(ack_n), .IRQ(irq));
  ivm_cpu_model cpu (.clk(clk), .int_req(int_req), .go(go), .lag(lag), .fetch(fetch));

  // Clock of 25 ns.
  initial forever #12.5 clk = ~clk;

  task chk(input string n, input [31:0] s, input [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Holds the request until waitrequest is sampled low; the bound guards a hang.
  task bus(input w, input [3:0] a, input [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (wait_r !== 1'b0 && k < 20);
    q = rdata;
    chk("waitrequest", wait_r, 0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rdc(input string n, input [3:0] a, input [31:0] e);
    bus(0, a, 0);
    chk(n, q, e);
  endtask
  task pulse(input [18:0] m);
    @(posedge clk);
    src <= m;
    @(posedge clk);
    src <= 19'h0;
  endtask
  task pin(input [4:0] m, input int n);
    @(posedge clk);
    pn <= ~m;
    repeat (n) @(posedge clk);
    pn <= 5'h1F;
  endtask
  task take(input [4:0] s);
    int k;
    k = 0;
    while (fetch !== 1'b1 && k < 60) begin
      @(posedge clk);
      k++;
    end
    chk("fetch", fetch, 1);
    chk("slot", slot, {27'h0, s});
    @(posedge clk);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task t_reset;
    repeat (4) @(negedge clk);
    chk("req", int_req, 1);
    for (int a = 0; a < 16; a++) if (a != 7 && a != 9) rdc("reg", a[3:0], 0);
    go <= 1;
    take(0);
    go <= 0;
    $display("t_reset end");
  endtask
  // Each source but the watchdog alone must land on its own slot and stay unserviced while masked.
  task t_map;
    byte sl[18] = '{4, 22, 5, 6, 17, 7, 8, 18, 9, 20, 21, 14, 15, 10, 23, 24, 25, 26};
    reg [31:0] e;
    for (int i = 0; i < 18; i++) begin
      pulse(19'h1 << i);
      e = 32'h1 << sl[i];
      rdc("pend lo", `IVM_A_PEND_LO, {16'h0, e[15:0]});
      rdc("pend hi", `IVM_A_PEND_HI, {16'h0, e[31:16]});
      chk("req", int_req, 0);
      bus(1, `IVM_A_PEND_LO, 32'hFFFF);
      bus(1, `IVM_A_PEND_HI, 32'hFFFF);
    end
    $display("t_map end");
  endtask
  task t_prio;
    byte ord[18] = '{24, 4, 5, 17, 6, 7, 8, 18, 9, 10, 20, 21, 14, 15, 22, 23, 25, 26};
    bus(1, `IVM_A_EN_LO, 32'hFFFC);
    bus(1, `IVM_A_EN_HI, 32'hFFFF);
    rdc("en lo", `IVM_A_EN_LO, 32'hFFFC);
    pulse(19'h3FFFF);
    go <= 1;
    for (int i = 0; i < 18; i++) take(ord[i][4:0]);
    go <= 0;
    rdc("pend lo", `IVM_A_PEND_LO, 0);
    rdc("pend hi", `IVM_A_PEND_HI, 0);
    $display("t_prio end");
  endtask
  // Halted enables are only rewritten while running, as software must do.
  task t_halt;
    halted <= 1;
    lag <= 4'h3;
    pulse(19'h1 << 13);
    repeat (10) @(posedge clk);
    chk("req", int_req, 0);
    halted <= 0;
    bus(1, `IVM_A_HEN_LO, 32'h0400);
    halted <= 1;
    go <= 1;
    take(10);
    halted <= 0;
    bus(1, `IVM_A_HEN_LO, 0);
    pulse(19'h1 << 13);
    take(10);
    go <= 0;
    lag <= 4'h0;
    $display("t_halt end");
  endtask
  task t_soft;
    bus(1, `IVM_A_HEN_LO, 32'h0400);
    pulse(19'h1 << 15);
    rdc("pend hi", `IVM_A_PEND_HI, 32'h0100);
    @(posedge clk);
    sreset <= 1;
    @(posedge clk);
    sreset <= 0;
    rdc("pend hi", `IVM_A_PEND_HI, 0);
    rdc("en lo", `IVM_A_EN_LO, 32'hFFFC);
    rdc("hen lo", `IVM_A_HEN_LO, 32'h0400);
    chk("slot", slot, 0);
    go <= 1;
    take(0);
    go <= 0;
    $display("t_soft end");
  endtask
  // A two-clock low is too short; routing swaps the pin for the watchdog.
  task t_pins;
    pin(5'h08, 3);
    repeat (8) @(posedge clk);
    rdc("ext3", `IVM_A_PEND_LO, 32'h0800);
    bus(1, `IVM_A_PEND_LO, 32'hFFFF);
    pin(5'h01, 2);
    repeat (8) @(posedge clk);
    rdc("short", `IVM_A_PEND_LO, 0);
    bus(1, `IVM_A_CTRL, 1);
    pin(5'h08, 3);
    repeat (8) @(posedge clk);
    rdc("routed", `IVM_A_PEND_LO, 0);
    pulse(19'h1 << 18);
    rdc("wdog", `IVM_A_PEND_LO, 32'h0800);
    bus(1, `IVM_A_PEND_LO, 32'hFFFF);
    bus(1, `IVM_A_CTRL, 0);
    pulse(19'h1 << 18);
    rdc("wdog off", `IVM_A_PEND_LO, 0);
    bus(1, `IVM_A_EN_LO, 0);
    go <= 1;
    pin(5'h10, 3);
    take(1);
    go <= 0;
    $display("t_pins end");
  endtask
  task t_irq;
    bus(1, `IVM_A_IRQ_STAT, 3);
    bus(1, `IVM_A_IRQ_MASK, 1);
    repeat (2) @(negedge clk);
    chk("irq", irq, 0);
    pulse(19'h1 << 14);
    repeat (2) @(negedge clk);
    chk("irq", irq, 1);
    rdc("stat", `IVM_A_IRQ_STAT, 1);
    bus(1, `IVM_A_IRQ_STAT, 1);
    repeat (2) @(negedge clk);
    chk("irq", irq, 0);
    bus(1, `IVM_A_IRQ_MASK, 2);
    pulse(19'h1 << 14);
    repeat (2) @(negedge clk);
    chk("irq", irq, 0);
    // Under this mask only the acknowledge event may raise the line.
    go <= 1;
    take(23);
    go <= 0;
    repeat (2) @(negedge clk);
    chk("irq", irq, 1);
    rdc("stat", `IVM_A_IRQ_STAT, 3);
    $display("t_irq end");
  endtask

  // Whole run is a few hundred cycles; this limit of 20000 cycles is far past it.
  initial begin
    #500000;
    fail_count++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_map;
    t_prio;
    t_halt;
    t_soft;
    t_pins;
    t_irq;
    test_done;
  end
endmodule
